// ---- cgc_pkg.sv ----
package cgc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] CGC_IDX_STATUS = 8'haa;
	localparam logic [7:0] CGC_IDX_INTR   = 8'h9b;
	localparam logic [7:0] CGC_IDX_CTRL   = 8'hab;
	// General control fields
	localparam int CGC_C_ABORT  = 7;
	localparam int CGC_C_OVLREQ = 6;
	localparam int CGC_C_TTC    = 5;
	localparam int CGC_C_SYNC   = 4;
	localparam int CGC_C_LISTEN = 3;
	localparam int CGC_C_TEST   = 2;
	localparam int CGC_C_ENA    = 1;
	localparam int CGC_C_SRST   = 0;
	// General status fields
	localparam int CGC_S_OVL  = 6;
	localparam int CGC_S_TRANSMITTER_BUSY_FLAG = 4;
	localparam int CGC_S_RECEIVER_BUSY_FLAG = 3;
	localparam int CGC_S_ENABLE_STATE_FLAG = 2;
	localparam int CGC_S_BUS_OFF_FLAG = 1;
	localparam int CGC_S_ERROR_PASSIVE_FLAG = 0;
	// General interrupt fields
	localparam int CGC_I_SUM  = 7;
	localparam int CGC_I_TIM  = 5;
	localparam int CGC_I_BUF  = 4;
	localparam int CGC_I_STF  = 3;
	localparam int CGC_I_CRC  = 2;
	localparam int CGC_I_FRM  = 1;
	localparam int CGC_I_ACK  = 0;
	// Sticky flags that software clears by writing zero
	localparam logic [7:0] CGC_I_CLR_MASK = 8'h3f;
	localparam logic [7:0] CGC_RST_8      = 8'h00;
	// Timing and protocol constants
	localparam int CGC_CLK_MHZ   = 50;
	localparam int CGC_WAKE_CLKS = 2;
	localparam int CGC_STUFF_MAX = 5;
	localparam logic [14:0] CGC_CRC_POLY = 15'h4599;
	localparam logic [7:0]  CGC_PASSIVE_LIM = 8'h7f;
	// AHB transfer type
	localparam logic [1:0] CGC_HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] CGC_HTRANS_SEQ    = 2'b11;
	// Protocol engine status, same clock as the bus
	typedef struct packed {
		logic tx_busy;     // Transmitter sending or frame pending
		logic rx_busy;     // Receiver acquiring or monitoring
		logic ovl_sending; // Own overload frame on the wire
		logic ovl_start;   // Pulse: own overload frame begins
		logic bus_off;     // Fault confinement says bus off
		logic sof;         // Pulse: start of frame
		logic eof_last;    // Pulse: last bit of end of frame
	} cgc_eng_t;
	// Engine error and overrun events, one-cycle pulses
	typedef struct packed {
		logic timer_wrap;
		logic buf_full;
		logic form_err;
		logic ack_err;
	} cgc_evt_t;
	// Destuffed bit stream for the CRC check
	typedef struct packed {
		logic        bit_stb;  // Destuffed bit valid
		logic        bit_val;  // Its value
		logic        in_span;  // Bit lies between SOF and data end
		logic        chk_stb;  // Pulse: received CRC field complete
		logic [14:0] rx_crc;   // Received CRC field
	} cgc_crc_t;
	typedef enum logic [1:0] {
		CGC_OFF   = 2'b00,
		CGC_WAKE  = 2'b01,
		CGC_ON    = 2'b10,
		CGC_DRAIN = 2'b11
	} cgc_state_t;
endpackage

// ---- cgc_global.sv ----
module cgc_global
	import cgc_pkg::*;
#(
	parameter int WAKE_CLKS = CGC_WAKE_CLKS
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire cgc_eng_t    eng,
	input  wire cgc_evt_t    evt,
	input  wire cgc_crc_t    crc_in,
	input  wire logic        sample_stb,
	input  wire logic        stuff_span,
	input  wire logic [7:0]  tec,
	input  wire logic [7:0]  rec,
	input  wire logic        timer_irq_enable,
	input  wire logic        buf_irq_enable,
	input  wire logic        err_irq_enable,
	input  wire logic        obj_irq,
	input  wire logic        eng_tx,
	input  wire logic        can_rx_pin,
	output logic             can_tx_pin,
	output logic             can_rx_bit,
	output logic             ctrl_clk_en,
	output logic             eng_run,
	output logic             ctrl_reset,
	output logic             listen_mode,
	output logic             tt_mode,
	output logic             test_mode,
	output logic             abort_req,
	output logic             ovl_req,
	output logic             tt_capture,
	output logic             timer_irq_req
);
	// Refuse a start delay the counter cannot hold
	if (WAKE_CLKS < 1 || WAKE_CLKS > 15) begin : g_wake_range
		$error("WAKE_CLKS out of range");
	end

	// Word address match for a register index
	// Upper address bits must be zero, so aliases never match
	function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
		hit = (a[31:10] == 22'h00_0000) && (a[9:0] == {idx, 2'b00});
	endfunction

	logic [7:0]  ctrl_reg;       // General control
	logic [7:0]  flag_reg;       // Sticky event flags, bits 5..0
	logic        srst_reg;       // Soft reset pulse
	cgc_state_t  state_reg;      // Enable state machine
	logic [3:0]  wake_reg;       // Start delay counter
	logic        wr_pend_reg;    // Write data phase pending
	logic        rd_pend_reg;    // Read data phase pending
	logic [7:0]  wr_idx_reg;     // Latched write index
	logic [7:0]  rd_idx_reg;     // Latched read index
	logic        wr_ok_reg;      // Latched write address mapped
	logic        rd_ok_reg;      // Latched read address mapped
	logic [1:0]  rx_sync_reg;    // Receive pin synchroniser
	logic [2:0]  run_len_reg;    // Equal-bit run length
	logic        last_bit_reg;   // Previous sampled bus bit
	logic [14:0] crc_reg;        // Running CRC
	logic [7:0]  status_w;       // Assembled status
	logic [7:0]  intr_w;         // Assembled interrupt register
	logic        sum_w;          // Interrupt summary
	logic        accept_w;       // Address phase accepted
	logic        stuff_err_w;    // Stuff violation this cycle
	logic        crc_err_w;      // CRC mismatch this cycle
	logic [14:0] crc_next;       // Next CRC value
	logic [7:0]  set_w;          // Flag set pulses

	// Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored
	assign accept_w = hsel && hready && (htrans == CGC_HTRANS_NONSEQ || htrans == CGC_HTRANS_SEQ);

	// AHB address phase capture and wait-state for reads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			wr_idx_reg  <= CGC_RST_8;
			rd_idx_reg  <= CGC_RST_8;
			wr_ok_reg   <= 1'b0;
			rd_ok_reg   <= 1'b0;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			wr_pend_reg <= accept_w && hwrite;
			rd_pend_reg <= accept_w && !hwrite;
			// Reads take one wait state so a preceding write lands first
			hreadyout   <= !(accept_w && !hwrite);
			if (accept_w) begin
				wr_idx_reg <= haddr[9:2];
				rd_idx_reg <= haddr[9:2];
				wr_ok_reg  <= hit(haddr, CGC_IDX_CTRL) || hit(haddr, CGC_IDX_INTR);
				rd_ok_reg  <= hit(haddr, CGC_IDX_CTRL) || hit(haddr, CGC_IDX_INTR) ||
					hit(haddr, CGC_IDX_STATUS);
			end
		end
	end

	// Read data, loaded in the wait state; unmapped reads return zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend_reg) begin
			if (!rd_ok_reg) begin
				hrdata <= 32'h0000_0000;
			end else if (rd_idx_reg == CGC_IDX_CTRL) begin
				hrdata <= {24'h00_0000, ctrl_reg};
			end else if (rd_idx_reg == CGC_IDX_INTR) begin
				hrdata <= {24'h00_0000, intr_w};
			end else begin
				hrdata <= {24'h00_0000, status_w};
			end
		end
	end

	// General control register; any reset leaves the controller disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= CGC_RST_8;
			srst_reg <= 1'b0;
		end else if (srst_reg) begin
			ctrl_reg <= CGC_RST_8;
			srst_reg <= 1'b0;
		end else begin
			srst_reg <= wr_pend_reg && wr_ok_reg && wr_idx_reg == CGC_IDX_CTRL &&
				hwdata[CGC_C_SRST];
			if (wr_pend_reg && wr_ok_reg && wr_idx_reg == CGC_IDX_CTRL) begin
				// Writable whether enabled or not
				ctrl_reg <= {hwdata[7:1], 1'b0};
			end
			// Overload request clears when its frame begins; hardware wins
			if (eng.ovl_start) begin
				ctrl_reg[CGC_C_OVLREQ] <= 1'b0;
			end
		end
	end

	// Enable state machine: delayed start, drain before freeze
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= CGC_OFF;
			wake_reg  <= 4'h0;
		end else if (srst_reg) begin
			state_reg <= CGC_OFF;
			wake_reg  <= 4'h0;
		end else begin
			unique case (state_reg)
				CGC_OFF: begin
					if (ctrl_reg[CGC_C_ENA]) begin
						state_reg <= CGC_WAKE;
						wake_reg  <= 4'h1;
					end
				end
				CGC_WAKE: begin
					if (!ctrl_reg[CGC_C_ENA]) begin
						state_reg <= CGC_OFF;
					end else if (wake_reg == 4'(WAKE_CLKS)) begin
						state_reg <= CGC_ON;
					end else begin
						wake_reg <= wake_reg + 4'h1;
					end
				end
				CGC_ON: begin
					if (!ctrl_reg[CGC_C_ENA]) begin
						state_reg <= CGC_DRAIN;
					end
				end
				CGC_DRAIN: begin
					if (!eng.tx_busy && !eng.rx_busy) begin
						state_reg <= CGC_OFF;
					end
				end
			endcase
		end
	end

	// Engine run, clock gate and pin drive from the state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			eng_run     <= 1'b0;
			ctrl_clk_en <= 1'b0;
			can_tx_pin  <= 1'b1;
			can_rx_bit  <= 1'b1;
			ctrl_reset  <= 1'b1;
		end else begin
			eng_run     <= state_reg == CGC_ON || state_reg == CGC_DRAIN;
			ctrl_clk_en <= state_reg != CGC_OFF;
			// Recessive when frozen, receiver input held idle
			can_tx_pin  <= (state_reg == CGC_ON || state_reg == CGC_DRAIN) ? eng_tx : 1'b1;
			can_rx_bit  <= (state_reg == CGC_ON || state_reg == CGC_DRAIN) ? rx_sync_reg[1] : 1'b1;
			ctrl_reset  <= srst_reg;
		end
	end

	// Mode outputs from the control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			listen_mode <= 1'b0;
			tt_mode     <= 1'b0;
			test_mode   <= 1'b0;
			abort_req   <= 1'b0;
			ovl_req     <= 1'b0;
			tt_capture  <= 1'b0;
		end else begin
			listen_mode <= ctrl_reg[CGC_C_LISTEN];
			tt_mode     <= ctrl_reg[CGC_C_TTC];
			test_mode   <= ctrl_reg[CGC_C_TEST];
			abort_req   <= ctrl_reg[CGC_C_ABORT];
			ovl_req     <= ctrl_reg[CGC_C_OVLREQ];
			// Capture point chosen by the sync bit, only in TT mode
			tt_capture  <= ctrl_reg[CGC_C_TTC] &&
				(ctrl_reg[CGC_C_SYNC] ? eng.eof_last : eng.sof);
		end
	end

	// Receive pin synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_sync_reg <= 2'b11;
		end else begin
			rx_sync_reg <= {rx_sync_reg[0], can_rx_pin};
		end
	end

	// Run length of equal bus bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_len_reg  <= 3'h0;
			last_bit_reg <= 1'b1;
		end else if (sample_stb) begin
			last_bit_reg <= rx_sync_reg[1];
			if (!stuff_span || rx_sync_reg[1] != last_bit_reg) begin
				run_len_reg <= 3'h1;
			end else if (run_len_reg != 3'h7) begin
				run_len_reg <= run_len_reg + 3'h1;
			end
		end
	end
	// Sixth equal bit in a stuffed field is a violation
	assign stuff_err_w = sample_stb && stuff_span && rx_sync_reg[1] == last_bit_reg &&
		run_len_reg == 3'(CGC_STUFF_MAX);

	// CRC-15 shift over destuffed bits
	always_comb begin
		crc_next = {crc_reg[13:0], 1'b0};
		if (crc_in.bit_val ^ crc_reg[14]) begin
			crc_next = crc_next ^ CGC_CRC_POLY;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crc_reg <= 15'h0000;
		end else if (eng.sof) begin
			crc_reg <= 15'h0000;
		end else if (crc_in.bit_stb && crc_in.in_span) begin
			crc_reg <= crc_next;
		end
	end
	assign crc_err_w = crc_in.chk_stb && crc_in.rx_crc != crc_reg;

	// Sticky flags: a set in the clearing cycle wins
	assign set_w = {2'b00, evt.timer_wrap, evt.buf_full, stuff_err_w, crc_err_w,
		evt.form_err, evt.ack_err};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_reg <= CGC_RST_8;
		end else if (srst_reg) begin
			flag_reg <= CGC_RST_8;
		end else if (wr_pend_reg && wr_ok_reg && wr_idx_reg == CGC_IDX_INTR) begin
			flag_reg <= (flag_reg & hwdata[7:0] & CGC_I_CLR_MASK) | set_w;
		end else begin
			flag_reg <= flag_reg | set_w;
		end
	end

	// Timer interrupt request follows flag and enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_irq_req <= 1'b0;
		end else begin
			timer_irq_req <= flag_reg[CGC_I_TIM] && timer_irq_enable;
		end
	end

	// Summary of every request toward the interrupt controller
	assign sum_w = timer_irq_req || (flag_reg[CGC_I_BUF] && buf_irq_enable) ||
		(|flag_reg[CGC_I_STF:CGC_I_ACK] && err_irq_enable) || obj_irq;
	assign intr_w = {sum_w, 1'b0, flag_reg[5:0]};

	// Status assembly; busy and overload flags feed no interrupt
	assign status_w = {1'b0, eng.ovl_sending, 1'b0, eng.tx_busy, eng.rx_busy,
		state_reg == CGC_ON || state_reg == CGC_DRAIN,
		eng.bus_off, !eng.bus_off && (tec > CGC_PASSIVE_LIM || rec > CGC_PASSIVE_LIM)};

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Checks on the enable machine, the pins and the sticky flags
	chk_wake_two: assert property ((state_reg == CGC_OFF && ctrl_reg[CGC_C_ENA] && !srst_reg)
		##1 (ctrl_reg[CGC_C_ENA] && !srst_reg) [*2] |=> state_reg == CGC_ON)
		else $error("engine did not start after wake delay");
	chk_no_early_run: assert property ($rose(ctrl_reg[CGC_C_ENA]) && state_reg == CGC_OFF
		|=> !eng_run ##1 !eng_run)
		else $error("engine ran before wake delay");
	chk_drain_hold: assert property (state_reg == CGC_DRAIN && (eng.tx_busy || eng.rx_busy) && !srst_reg
		|=> state_reg == CGC_DRAIN)
		else $error("froze during a frame");
	chk_standby_tx: assert property (state_reg == CGC_OFF |=> can_tx_pin)
		else $error("transmit not recessive in standby");
	chk_srst_clear: assert property (srst_reg |=> !srst_reg && state_reg == CGC_OFF
		&& !ctrl_reg[CGC_C_ENA] && ctrl_reset)
		else $error("soft reset incomplete");
	chk_flag_set: assert property (evt.ack_err && !srst_reg |=> flag_reg[CGC_I_ACK])
		else $error("ack error lost");
	chk_frm_set: assert property (evt.form_err && !srst_reg |=> flag_reg[CGC_I_FRM])
		else $error("form error lost");
	chk_buf_hold: assert property (flag_reg[CGC_I_BUF] && !(wr_pend_reg && wr_idx_reg == CGC_IDX_INTR)
		&& !srst_reg |=> flag_reg[CGC_I_BUF])
		else $error("buffer flag dropped without software");
	chk_tim_req: assert property (flag_reg[CGC_I_TIM] && timer_irq_enable |=> timer_irq_req)
		else $error("timer request missing");
	chk_crc_flag: assert property (crc_err_w && !srst_reg |=> flag_reg[CGC_I_CRC])
		else $error("crc error lost");
	chk_capture_sel: assert property (tt_capture |-> $past(ctrl_reg[CGC_C_TTC]))
		else $error("capture outside time-triggered mode");
	chk_enable_state_flag: assert property (status_w[CGC_S_ENABLE_STATE_FLAG] == eng_run || $changed(state_reg))
		else $error("enable flag disagrees with engine");
	chk_listen_mode: assert property (listen_mode == $past(ctrl_reg[CGC_C_LISTEN]))
		else $error("listen mode does not follow its bit");
	chk_rx_idle: assert property (state_reg == CGC_OFF |=> can_rx_bit)
		else $error("receiver not idle in standby");

	// Main scenarios: start, drain, stuff violation, flag clear, soft reset
	cov_soft_reset: cover property (srst_reg ##1 ctrl_reset);
	cov_start: cover property (state_reg == CGC_WAKE ##[1:4] state_reg == CGC_ON);
	cov_drain: cover property (state_reg == CGC_DRAIN ##[1:50] state_reg == CGC_OFF);
	cov_stuff: cover property (stuff_err_w);
	cov_clear: cover property (flag_reg[CGC_I_ACK] ##1 !flag_reg[CGC_I_ACK]);
endmodule

// ---- cgc_can_node.sv ----
// Remote bus node seen through a transceiver; the bus is a wired-AND
module cgc_can_node (
	input  wire logic hclk,     // Controller clock
	input  wire logic tx_pin,   // Our transmit drive, high is recessive
	input  wire logic node_dom, // Remote node pulls the bus dominant
	output logic      rx_pin    // Bus level looped back to our receiver
);
	timeunit 1ns;
	timeprecision 1ns;
	// Recessive bus until the first edge
	initial rx_pin = 1'h1;
	// Wired-AND with one cycle of transceiver loop delay
	always @(posedge hclk) begin
		rx_pin <= tx_pin & ~node_dom;
	end
endmodule

// ---- testbench.sv ----
module testbench
	import cgc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 1'h0;       // Bus clock
	logic        hresetn = 1'h0;    // Bus reset, active low
	logic        hsel = 1'h0;       // Slave select
	logic [31:0] haddr = '0;        // Byte address
	logic [1:0]  htrans = 2'h0;     // Transfer type
	logic        hwrite = 1'h0;     // Write strobe
	logic [31:0] hwdata = '0;       // Write data
	logic [31:0] hrdata;            // Read data
	logic        hreadyout, hresp;  // Slave answer
	cgc_eng_t    eng = '0;          // Engine status
	cgc_evt_t    evt = '0;          // Engine events
	cgc_crc_t    crc_in = '0;       // Destuffed bit stream
	logic        sample_stb = 1'h0; // Sample point strobe
	logic        stuff_span = 1'h0; // Stuffing applies
	logic [7:0]  tec = '0, rec = '0; // Error counters
	logic [3:0]  irq_en = '0;       // Timer, buffer, error enables, object request
	logic        eng_tx = 1'h1;     // Engine transmit bit
	logic        node_dom = 1'h0;   // Remote node dominant
	logic        can_rx_pin, can_tx_pin, can_rx_bit, ctrl_clk_en, eng_run;
	logic        listen_mode, tt_mode, test_mode, tt_capture, timer_irq_req;
	logic        ctrl_reset, abort_req, ovl_req; // Reset pulse and request outputs
	logic [31:0] seed = 32'h0001_2d12; // Random generator state
	int          errors = 0;         // Mismatches
	int          checked = 0;        // Comparisons
	int          cycles = 0;         // Hang guard
	int          fb[4] = '{CGC_I_TIM, CGC_I_BUF, CGC_I_FRM, CGC_I_ACK}; // Flag of each event

	cgc_global dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .eng(eng), .evt(evt), .crc_in(crc_in),
		.sample_stb(sample_stb), .stuff_span(stuff_span), .tec(tec), .rec(rec),
		.timer_irq_enable(irq_en[3]), .buf_irq_enable(irq_en[2]), .err_irq_enable(irq_en[1]),
		.obj_irq(irq_en[0]), .eng_tx(eng_tx), .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin),
		.can_rx_bit(can_rx_bit), .ctrl_clk_en(ctrl_clk_en), .eng_run(eng_run), .ctrl_reset(ctrl_reset),
		.listen_mode(listen_mode), .tt_mode(tt_mode), .test_mode(test_mode), .abort_req(abort_req),
		.ovl_req(ovl_req), .tt_capture(tt_capture), .timer_irq_req(timer_irq_req));
	cgc_can_node node (.hclk(hclk), .tx_pin(can_tx_pin), .node_dom(node_dom), .rx_pin(can_rx_pin));

	// Free-running bus clock
	always #10 hclk = ~hclk;

	// Hang guard
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			results();
		end
	end

	// Next random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// One bit of the frame check sequence
	function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
		return (c << 1) ^ ((b ^ c[14]) ? CGC_CRC_POLY : 15'h0000);
	endfunction

	// Expected general status byte
	function automatic logic [7:0] exp_status(input cgc_eng_t e, input logic [7:0] t, r);
		logic [7:0] s;
		s = '0;
		s[CGC_S_OVL]  = e.ovl_sending;
		s[CGC_S_TRANSMITTER_BUSY_FLAG] = e.tx_busy;
		s[CGC_S_RECEIVER_BUSY_FLAG] = e.rx_busy;
		s[CGC_S_ENABLE_STATE_FLAG] = 1'h1;
		s[CGC_S_BUS_OFF_FLAG] = e.bus_off;
		s[CGC_S_ERROR_PASSIVE_FLAG] = !e.bus_off && (t > CGC_PASSIVE_LIM || r > CGC_PASSIVE_LIM);
		return s;
	endfunction

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single word transfer
	task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'h1;
		haddr  <= {22'h0, idx, 2'h0};
		htrans <= CGC_HTRANS_NONSEQ;
		hwrite <= wr_en;
		@(posedge hclk);
		while (hreadyout !== 1'h1)
			@(posedge hclk);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'h1)
			@(posedge hclk);
		rd = hrdata;
		check(hresp, 1'h0);
	endtask

	// Register write
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'h1, idx, wd, d);
	endtask

	// Register read and compare
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		bus(1'h0, idx, 32'h0000_0000, d);
		check(d, {24'h0, exp});
	endtask

	// Verdict and end of run
	task automatic results();
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		logic [7:0]  v, t, r;
		logic [31:0] n;
		logic [14:0] c;
		cgc_eng_t    e;
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd_chk(CGC_IDX_CTRL, 8'h00);
		rd_chk(CGC_IDX_INTR, 8'h00);
		rd_chk(8'h00, 8'h00);
		check(can_tx_pin, 1'h1);
		// Control image while disabled; test bit always clear
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			v = seed[7:0] & 8'h38;
			wr(CGC_IDX_CTRL, {24'h0, v});
			rd_chk(CGC_IDX_CTRL, v);
			check(listen_mode, v[CGC_C_LISTEN]);
			check(tt_mode, v[CGC_C_TTC]);
			check(test_mode, 1'h0);
		end
		// Abort and overload requests; the overload start clears its request
		wr(CGC_IDX_CTRL, 32'h0000_00c0);
		rd_chk(CGC_IDX_CTRL, 8'hc0);
		check(abort_req, 1'h1);
		check(ovl_req, 1'h1);
		eng <= cgc_eng_t'(7'h08);
		@(posedge hclk);
		eng <= '0;
		rd_chk(CGC_IDX_CTRL, 8'h80);
		check(ovl_req, 1'h0);
		check(abort_req, 1'h1);
		// Enable and wake-up delay
		wr(CGC_IDX_CTRL, 32'h0000_0002);
		repeat (2) @(posedge hclk);
		check(eng_run, 1'h0);
		repeat (3) @(posedge hclk);
		check(eng_run, 1'h1);
		check(ctrl_clk_en, 1'h1);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			eng_tx <= seed[0];
			repeat (3) @(posedge hclk);
			check(can_tx_pin, seed[0]);
		end
		// Status image, first pass at the passive boundary
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			e = cgc_eng_t'(seed[6:0] & 7'h74);
			t = (i == 0) ? 8'h80 : seed[15:8];
			r = (i == 0) ? 8'h7f : seed[23:16];
			eng <= e;
			tec <= t;
			rec <= r;
			repeat (2) @(posedge hclk);
			rd_chk(CGC_IDX_STATUS, exp_status(e, t, r));
		end
		eng <= '0;
		tec <= '0;
		rec <= '0;
		// Sticky events, summary and clearing
		irq_en <= 4'he;
		for (int k = 0; k < 5; k++) begin
			if (k == 4)
				irq_en <= 4'h0;
			evt <= cgc_evt_t'(4'h8 >> (k % 4));
			@(posedge hclk);
			evt <= '0;
			v = (8'h01 << fb[k % 4]) | ((k < 4) ? 8'h80 : 8'h00);
			rd_chk(CGC_IDX_INTR, v);
			check(timer_irq_req, k == 0);
			wr(CGC_IDX_INTR, {24'h0, CGC_I_CLR_MASK & ~v});
			rd_chk(CGC_IDX_INTR, 8'h00);
		end
		irq_en <= 4'h1;
		@(posedge hclk);
		rd_chk(CGC_IDX_INTR, 8'h80);
		irq_en <= 4'h2;
		// Six equal dominant samples make a stuff error, five do not
		node_dom <= 1'h1;
		stuff_span <= 1'h1;
		repeat (4) @(posedge hclk);
		for (int i = 1; i <= 6; i++) begin
			sample_stb <= 1'h1;
			@(posedge hclk);
			sample_stb <= 1'h0;
			@(posedge hclk);
			if (i == 5)
				rd_chk(CGC_IDX_INTR, 8'h00);
		end
		rd_chk(CGC_IDX_INTR, 8'h88);
		wr(CGC_IDX_INTR, 32'h0000_0000);
		// Check sequence over random bits, good then corrupted
		for (int k = 0; k < 2; k++) begin
			eng <= cgc_eng_t'(7'h02);
			c = '0;
			@(posedge hclk);
			eng <= '0;
			for (int i = 0; i < 8; i++) begin
				seed = lfsr(seed);
				c = crc_step(c, seed[0]);
				crc_in <= {1'h1, seed[0], 1'h1, 1'h0, 15'h0000};
				@(posedge hclk);
			end
			crc_in <= {3'h0, 1'h1, c ^ 15'(k)};
			@(posedge hclk);
			crc_in <= '0;
			@(posedge hclk);
			rd_chk(CGC_IDX_INTR, k ? 8'h84 : 8'h00);
		end
		wr(CGC_IDX_INTR, 32'h0000_0000);
		// Timer capture point for each mode and select setting
		for (int m = 0; m < 3; m++) begin
			wr(CGC_IDX_CTRL, (m == 0) ? 32'h0000_0002 : (m == 1) ? 32'h0000_0022 : 32'h0000_0032);
			for (int p = 0; p < 2; p++) begin
				eng <= cgc_eng_t'(p ? 7'h01 : 7'h02);
				@(posedge hclk);
				eng <= '0;
				n = '0;
				repeat (4) begin
					@(posedge hclk);
					n = n + tt_capture;
				end
				check(n, m != 0 && p == m - 1);
			end
		end
		// Disable waits for the frame in progress, then standby
		eng <= cgc_eng_t'(7'h40);
		eng_tx <= 1'h0;
		wr(CGC_IDX_CTRL, 32'h0000_0000);
		repeat (6) @(posedge hclk);
		check(eng_run, 1'h1);
		eng <= '0;
		repeat (6) @(posedge hclk);
		check(eng_run, 1'h0);
		check(ctrl_clk_en, 1'h0);
		check(can_tx_pin, 1'h1);
		check(can_rx_bit, 1'h1);
		rd_chk(CGC_IDX_STATUS, 8'h00);
		// Soft reset from the running state
		wr(CGC_IDX_CTRL, 32'h0000_0002);
		repeat (6) @(posedge hclk);
		wr(CGC_IDX_CTRL, 32'h0000_0023);
		n = '0;
		repeat (6) begin
			@(posedge hclk);
			n = n + ctrl_reset;
		end
		check(n, 32'h0000_0001);
		check(eng_run, 1'h0);
		rd_chk(CGC_IDX_CTRL, 8'h00);
		results();
	end
endmodule
